/* include/sfc_defs.vh */
`ifndef SFC_DEFS_VH
`define SFC_DEFS_VH

// ****************************************************************
// Command opcodes
// ****************************************************************
`define SFC_OP_READ       8'h03
`define SFC_OP_FAST_READ  8'h0b
`define SFC_OP_PARAM_READ 8'h5a
`define SFC_OP_DUAL_READ  8'hbb
`define SFC_OP_W4_READ    8'he7
`define SFC_OP_QADR_READ  8'heb
`define SFC_OP_STAT_READ  8'h05
`define SFC_OP_STAT_WRITE 8'h01
`define SFC_OP_WR_EN      8'h06
`define SFC_OP_WR_DIS     8'h04
`define SFC_OP_QPAGE_PROG 8'h38
`define SFC_OP_SECT_ERASE 8'h20
`define SFC_OP_BLK32_ERA  8'h52
`define SFC_OP_BLK64_ERA  8'hd8
`define SFC_OP_CHIP_ERA_A 8'h60
`define SFC_OP_CHIP_ERA_B 8'hc7
`define SFC_OP_PAGE_PROG  8'h02
`define SFC_OP_PWR_DOWN   8'hb9
`define SFC_OP_PWR_UP     8'hab
`define SFC_OP_SUSPEND    8'hb0
`define SFC_OP_RESUME     8'h30
`define SFC_OP_QUAD_ENTRY 8'h35
`define SFC_OP_QUAD_EXIT  8'hf5

// ****************************************************************
// Command attribute word fields
// ****************************************************************
`define SFC_A_W      13
`define SFC_A_VALID  0
`define SFC_A_READ   1
`define SFC_A_ADDR   2
`define SFC_A_ALN    4:3
`define SFC_A_DUM    8:5
`define SFC_A_DLN    10:9
`define SFC_A_ARRAY  11
`define SFC_A_DIN    12

// ****************************************************************
// Lane codes and phase counts
// ****************************************************************
`define SFC_LN1        2'h0
`define SFC_LN2        2'h1
`define SFC_LN4        2'h2
`define SFC_DUMMY_NONE 4'h0
`define SFC_DUMMY_SPI  4'h8
`define SFC_DUMMY_QUAD 4'h4
`define SFC_DUMMY_FAST 4'h6
`define SFC_ADDR_BITS  5'h18
`define SFC_BYTE_BITS  4'h8

// ****************************************************************
// Array map: 4 KB sectors, 32 KB and 64 KB blocks
// ****************************************************************
`define SFC_SECT_RANGE  20:12
`define SFC_BLK32_RANGE 20:15
`define SFC_BLK64_RANGE 20:16

`endif

/* rtl/sfc_buf2.v */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Two-entry buffer, head entry drives the output
// ****************************************************************
module sfc_buf2 #(
  parameter W = 8
) (
  input  wire         clk_in,
  input  wire         rstn_in,
  input  wire [W-1:0] in_data_in,
  input  wire         in_valid_in,
  output wire         in_ready_out,
  output wire [W-1:0] out_data_out,
  output wire         out_valid_out,
  input  wire         out_ready_in
);

  reg [W-1:0] d0_r;
  reg [W-1:0] d1_r;
  reg         v0_r;
  reg         v1_r;

  wire pop  = v0_r & out_ready_in;
  wire push = in_valid_in & ~v1_r;

  // Outputs come straight from the entry registers
  assign in_ready_out  = ~v1_r;
  assign out_data_out  = d0_r;
  assign out_valid_out = v0_r;

  // Entry movement
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      d0_r <= {W{1'b0}};
      d1_r <= {W{1'b0}};
      v0_r <= 1'b0;
      v1_r <= 1'b0;
    end else if (pop && v1_r) begin
      d0_r <= d1_r;
      v1_r <= push;
      if (push) begin
        d1_r <= in_data_in;
      end
    end else if (pop || !v0_r) begin
      v0_r <= push;
      if (push) begin
        d0_r <= in_data_in;
      end
    end else if (push) begin
      v1_r <= 1'b1;
      d1_r <= in_data_in;
    end
  end

endmodule // sfc_buf2

`default_nettype wire

/* rtl/sfc_front_end.v */
// Behaviour
// - An unknown opcode puts the device in standby, ignoring clocks until the next chip select fall.
// - In standby the data output pin is not driven.
// - A known opcode, except an array access command while busy, makes the device active until chip select rises.
// - Inputs are sampled on rising serial clock edges and outputs change on falling edges.
// - Both clock idle levels, serial modes 0 and 3, are accepted.
// - Read-type commands end in a data-out phase that the host may cut after any bit.
// - Write-type commands execute only if chip select rises on a byte boundary, else they are dropped.
// - While an internal write, program or erase runs, array access commands are ignored.
// - Opcode 35h enters quad command mode, with all phases on four lines.
// - Opcode f5h in quad command mode returns to single-line operation.
// - Opcode ebh selects fast quad read with 6 dummy clocks instead of 4.
// - The array is split into 4 KB sectors, 32 KB and 64 KB blocks; sector 255 ends at 0fffffh.
`timescale 1ns/1ps
`default_nettype none
`include "sfc_defs.vh"

module sfc_front_end (
  input  wire        clk_in,
  input  wire        rstn_in,
  input  wire        cs_n_in,
  input  wire        sclk_in,
  input  wire [3:0]  io_in,
  output reg  [3:0]  io_out,
  output reg  [3:0]  io_oe_out,
  input  wire        busy_in,
  input  wire [7:0]  tx_data_in,
  output reg         tx_take_out,
  output wire [7:0]  rx_data_out,
  output wire        rx_valid_out,
  input  wire        rx_ready_in,
  output reg         rx_overrun_out,
  output reg  [7:0]  cmd_op_out,
  output reg  [23:0] cmd_addr_out,
  output reg  [8:0]  sector_out,
  output reg  [5:0]  block32_out,
  output reg  [4:0]  block64_out,
  output reg         cmd_exec_out,
  output reg         cmd_reject_out,
  output reg         active_out,
  output reg         standby_out,
  output reg         quad_command_mode_out,
  output reg         fast_quad_read_mode_out
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [6:0] ST_IDLE  = 7'h01;
  localparam [6:0] ST_OP    = 7'h02;
  localparam [6:0] ST_ADDR  = 7'h04;
  localparam [6:0] ST_DUMMY = 7'h08;
  localparam [6:0] ST_DOUT  = 7'h10;
  localparam [6:0] ST_DIN   = 7'h20;
  localparam [6:0] ST_STBY  = 7'h40;

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Pack one attribute word
  function [`SFC_A_W-1:0] mk;
    input       rd;
    input       ad;
    input [1:0] aln;
    input [3:0] dum;
    input [1:0] dln;
    input       arr;
    input       din;
    reg [`SFC_A_W-1:0] a;
    begin
      a = {`SFC_A_W{1'b0}};
      a[`SFC_A_VALID] = 1'b1;
      a[`SFC_A_READ]  = rd;
      a[`SFC_A_ADDR]  = ad;
      a[`SFC_A_ALN]   = aln;
      a[`SFC_A_DUM]   = dum;
      a[`SFC_A_DLN]   = dln;
      a[`SFC_A_ARRAY] = arr;
      a[`SFC_A_DIN]   = din;
      mk = a;
    end
  endfunction

  // Opcode decoder, zero word for an unknown opcode
  function [`SFC_A_W-1:0] cmd_attr;
    input [7:0] op;
    input       q;
    reg   [1:0] ln;
    reg   [`SFC_A_W-1:0] z;
    begin
      ln = q ? `SFC_LN4 : `SFC_LN1;
      z  = {`SFC_A_W{1'b0}};
      case (op)
        `SFC_OP_READ:       cmd_attr = q ? z : mk(1'b1, 1'b1, ln, `SFC_DUMMY_NONE, ln, 1'b1, 1'b0);
        `SFC_OP_FAST_READ:  cmd_attr = mk(1'b1, 1'b1, ln, q ? `SFC_DUMMY_QUAD : `SFC_DUMMY_SPI,
                                          ln, 1'b1, 1'b0);
        `SFC_OP_PARAM_READ: cmd_attr = q ? z : mk(1'b1, 1'b1, ln, `SFC_DUMMY_SPI, ln, 1'b0, 1'b0);
        `SFC_OP_DUAL_READ:  cmd_attr = q ? z : mk(1'b1, 1'b1, `SFC_LN2, `SFC_DUMMY_QUAD,
                                                  `SFC_LN2, 1'b1, 1'b0);
        `SFC_OP_W4_READ:    cmd_attr = q ? z : mk(1'b1, 1'b1, `SFC_LN4, `SFC_DUMMY_QUAD,
                                                  `SFC_LN4, 1'b1, 1'b0);
        `SFC_OP_QADR_READ:  cmd_attr = mk(1'b1, 1'b1, `SFC_LN4, `SFC_DUMMY_FAST,
                                          `SFC_LN4, 1'b1, 1'b0);
        `SFC_OP_STAT_READ:  cmd_attr = mk(1'b1, 1'b0, ln, `SFC_DUMMY_NONE, ln, 1'b0, 1'b0);
        `SFC_OP_STAT_WRITE: cmd_attr = mk(1'b0, 1'b0, ln, `SFC_DUMMY_NONE, ln, 1'b1, 1'b1);
        `SFC_OP_QPAGE_PROG: cmd_attr = mk(1'b0, 1'b1, `SFC_LN4, `SFC_DUMMY_NONE,
                                          `SFC_LN4, 1'b1, 1'b1);
        `SFC_OP_PAGE_PROG:  cmd_attr = mk(1'b0, 1'b1, ln, `SFC_DUMMY_NONE, ln, 1'b1, 1'b1);
        `SFC_OP_SECT_ERASE,
        `SFC_OP_BLK32_ERA,
        `SFC_OP_BLK64_ERA:  cmd_attr = mk(1'b0, 1'b1, ln, `SFC_DUMMY_NONE, ln, 1'b1, 1'b0);
        `SFC_OP_CHIP_ERA_A,
        `SFC_OP_CHIP_ERA_B: cmd_attr = mk(1'b0, 1'b0, ln, `SFC_DUMMY_NONE, ln, 1'b1, 1'b0);
        `SFC_OP_WR_EN,
        `SFC_OP_WR_DIS,
        `SFC_OP_PWR_DOWN,
        `SFC_OP_PWR_UP,
        `SFC_OP_SUSPEND,
        `SFC_OP_RESUME:     cmd_attr = mk(1'b0, 1'b0, ln, `SFC_DUMMY_NONE, ln, 1'b0, 1'b0);
        `SFC_OP_QUAD_ENTRY: cmd_attr = q ? z : mk(1'b0, 1'b0, ln, `SFC_DUMMY_NONE,
                                                  ln, 1'b0, 1'b0);
        `SFC_OP_QUAD_EXIT:  cmd_attr = q ? mk(1'b0, 1'b0, ln, `SFC_DUMMY_NONE,
                                              ln, 1'b0, 1'b0) : z;
        default:            cmd_attr = z;
      endcase
    end
  endfunction

  // Bits moved per clock for a lane code
  function [2:0] lane_w;
    input [1:0] ln;
    begin
      case (ln)
        `SFC_LN2: lane_w = 3'h2;
        `SFC_LN4: lane_w = 3'h4;
        default:  lane_w = 3'h1;
      endcase
    end
  endfunction

  // Shift sampled lanes into an 8-bit register, first bit ends up on top
  function [7:0] shift8;
    input [7:0] sh;
    input [3:0] io;
    input [1:0] ln;
    begin
      case (ln)
        `SFC_LN2: shift8 = {sh[5:0], io[1:0]};
        `SFC_LN4: shift8 = {sh[3:0], io[3:0]};
        default:  shift8 = {sh[6:0], io[0]};
      endcase
    end
  endfunction

  // Same for the 24-bit address
  function [23:0] shift24;
    input [23:0] sh;
    input [3:0]  io;
    input [1:0]  ln;
    begin
      case (ln)
        `SFC_LN2: shift24 = {sh[21:0], io[1:0]};
        `SFC_LN4: shift24 = {sh[19:0], io[3:0]};
        default:  shift24 = {sh[22:0], io[0]};
      endcase
    end
  endfunction

  // Output lanes: single line uses the data output pin io[1]
  function [3:0] out_bits;
    input [7:0] b;
    input [1:0] ln;
    begin
      case (ln)
        `SFC_LN2: out_bits = {2'h0, b[7:6]};
        `SFC_LN4: out_bits = b[7:4];
        default:  out_bits = {2'h0, b[7], 1'b0};
      endcase
    end
  endfunction

  function [3:0] oe_mask;
    input [1:0] ln;
    begin
      case (ln)
        `SFC_LN2: oe_mask = 4'h3;
        `SFC_LN4: oe_mask = 4'hf;
        default:  oe_mask = 4'h2;
      endcase
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  reg       cs_s1_r;
  reg       cs_s2_r;
  reg       cs_s3_r;
  reg       sclk_s1_r;
  reg       sclk_s2_r;
  reg       sclk_s3_r;
  reg [3:0] io_s1_r;
  reg [3:0] io_s2_r;

  // Two flops per pin, a third stage for edges
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      cs_s1_r   <= 1'b1;
      cs_s2_r   <= 1'b1;
      cs_s3_r   <= 1'b1;
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_s3_r <= 1'b0;
      io_s1_r   <= 4'h0;
      io_s2_r   <= 4'h0;
    end else begin
      cs_s1_r   <= cs_n_in;
      cs_s2_r   <= cs_s1_r;
      cs_s3_r   <= cs_s2_r;
      sclk_s1_r <= sclk_in;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      io_s1_r   <= io_in;
      io_s2_r   <= io_s1_r;
    end
  end

  // Edges only; the idle level of the clock never matters
  wire cs_fall   = ~cs_s2_r & cs_s3_r;
  wire cs_rise   = cs_s2_r & ~cs_s3_r;
  wire sclk_rise = sclk_s2_r & ~sclk_s3_r & ~cs_s2_r;
  wire sclk_fall = ~sclk_s2_r & sclk_s3_r & ~cs_s2_r;

  // ****************************************************************
  // Command state
  // ****************************************************************
  reg [6:0]          state_r;
  reg [`SFC_A_W-1:0] attr_r;
  reg [7:0]          sh_r;
  reg [2:0]          bitpos_r;
  reg [4:0]          acnt_r;
  reg [3:0]          dcnt_r;
  reg [7:0]          tx_sh_r;
  reg [3:0]          tx_left_r;
  reg                push_r;
  reg [7:0]          push_data_r;
  wire               buf_ready;

  // Lanes of the current input phase; in quad command mode the opcode uses four lines
  reg [1:0] cur_ln;
  always @* begin
    if (state_r == ST_OP) begin
      cur_ln = quad_command_mode_out ? `SFC_LN4 : `SFC_LN1;
    end else if (state_r == ST_ADDR) begin
      cur_ln = attr_r[`SFC_A_ALN];
    end else begin
      cur_ln = attr_r[`SFC_A_DLN];
    end
  end

  // Next values shared by the phases
  wire [2:0]          w        = lane_w(cur_ln);
  wire [3:0]          bp_sum   = {1'b0, bitpos_r} + {1'b0, w};
  wire                byte_end = bp_sum[3];
  wire [7:0]          sh_nxt   = shift8(sh_r, io_s2_r, cur_ln);
  wire [23:0]         addr_nxt = shift24(cmd_addr_out, io_s2_r, cur_ln);
  wire [4:0]          acnt_nxt = acnt_r + {2'h0, w};
  wire [3:0]          dcnt_nxt = dcnt_r + 4'h1;
  wire [`SFC_A_W-1:0] dec      = cmd_attr(sh_nxt, quad_command_mode_out);
  wire [2:0]          dw       = lane_w(attr_r[`SFC_A_DLN]);

  // Main sequencer
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      state_r                 <= ST_IDLE;
      quad_command_mode_out   <= 1'b0;
      attr_r                  <= {`SFC_A_W{1'b0}};
      sh_r                    <= 8'h00;
      bitpos_r                <= 3'h0;
      acnt_r                  <= 5'h00;
      dcnt_r                  <= 4'h0;
      tx_sh_r                 <= 8'h00;
      tx_left_r               <= 4'h0;
      push_r                  <= 1'b0;
      push_data_r             <= 8'h00;
      io_out                  <= 4'h0;
      io_oe_out               <= 4'h0;
      tx_take_out             <= 1'b0;
      rx_overrun_out          <= 1'b0;
      cmd_op_out              <= 8'h00;
      cmd_addr_out            <= 24'h000000;
      sector_out              <= 9'h000;
      block32_out             <= 6'h00;
      block64_out             <= 5'h00;
      cmd_exec_out            <= 1'b0;
      cmd_reject_out          <= 1'b0;
      active_out              <= 1'b0;
      standby_out             <= 1'b0;
      fast_quad_read_mode_out <= 1'b0;
    end else begin
      cmd_exec_out   <= 1'b0;
      cmd_reject_out <= 1'b0;
      tx_take_out    <= 1'b0;
      push_r         <= 1'b0;
      rx_overrun_out <= push_r & ~buf_ready; // Word lost to a full buffer
      if (cs_fall) begin
        // New frame: leaves standby
        state_r     <= ST_OP;
        bitpos_r    <= 3'h0;
        sh_r        <= 8'h00;
        acnt_r      <= 5'h00;
        dcnt_r      <= 4'h0;
        tx_left_r   <= 4'h0;
        standby_out <= 1'b0;
        io_oe_out   <= 4'h0;
      end else if (cs_rise) begin
        // Write-type commands run only on a byte boundary
        if (state_r == ST_DIN && !attr_r[`SFC_A_READ]) begin
          if (bitpos_r == 3'h0) begin
            cmd_exec_out <= 1'b1;
            if (cmd_op_out == `SFC_OP_QUAD_ENTRY) begin
              quad_command_mode_out <= 1'b1;
            end
            if (cmd_op_out == `SFC_OP_QUAD_EXIT) begin
              quad_command_mode_out <= 1'b0;
            end
          end else begin
            cmd_reject_out <= 1'b1;
          end
        end else if (state_r == ST_ADDR && !attr_r[`SFC_A_READ]) begin
          cmd_reject_out <= 1'b1;
        end
        state_r                 <= ST_IDLE;
        io_oe_out               <= 4'h0;
        active_out              <= 1'b0;
        fast_quad_read_mode_out <= 1'b0;
      end else if (sclk_rise) begin
        // Inputs are taken on rising edges only
        case (state_r)
          ST_OP: begin
            sh_r     <= sh_nxt;
            bitpos_r <= bp_sum[2:0];
            if (byte_end) begin
              cmd_op_out <= sh_nxt;
              attr_r     <= dec;
              if (!dec[`SFC_A_VALID]) begin
                state_r     <= ST_STBY;
                standby_out <= 1'b1;
              end else if (dec[`SFC_A_ARRAY] && busy_in) begin
                state_r        <= ST_STBY;
                cmd_reject_out <= 1'b1;
              end else begin
                active_out              <= 1'b1;
                fast_quad_read_mode_out <= (sh_nxt == `SFC_OP_QADR_READ);
                if (dec[`SFC_A_ADDR]) begin
                  state_r <= ST_ADDR;
                end else if (dec[`SFC_A_READ]) begin
                  state_r <= ST_DOUT;
                end else begin
                  state_r <= ST_DIN;
                end
              end
            end
          end
          ST_ADDR: begin
            cmd_addr_out <= addr_nxt;
            bitpos_r     <= bp_sum[2:0];
            acnt_r       <= acnt_nxt;
            if (acnt_nxt == `SFC_ADDR_BITS) begin
              sector_out  <= addr_nxt[`SFC_SECT_RANGE];
              block32_out <= addr_nxt[`SFC_BLK32_RANGE];
              block64_out <= addr_nxt[`SFC_BLK64_RANGE];
              if (attr_r[`SFC_A_DUM] != `SFC_DUMMY_NONE) begin
                state_r <= ST_DUMMY;
              end else if (attr_r[`SFC_A_READ]) begin
                state_r <= ST_DOUT;
              end else begin
                state_r <= ST_DIN;
              end
            end
          end
          ST_DUMMY: begin
            dcnt_r <= dcnt_nxt;
            if (dcnt_nxt == attr_r[`SFC_A_DUM]) begin
              state_r <= ST_DOUT;
            end
          end
          ST_DIN: begin
            sh_r     <= sh_nxt;
            bitpos_r <= bp_sum[2:0];
            if (byte_end && attr_r[`SFC_A_DIN]) begin
              push_r      <= 1'b1;
              push_data_r <= sh_nxt;
            end
          end
          default: begin
            // Idle and standby ignore clocks
          end
        endcase
      end else if (sclk_fall && state_r == ST_DOUT) begin
        // Outputs change on falling edges only; host may stop at any bit
        io_oe_out <= oe_mask(attr_r[`SFC_A_DLN]);
        if (tx_left_r == 4'h0) begin
          tx_take_out <= 1'b1;
          io_out      <= out_bits(tx_data_in, attr_r[`SFC_A_DLN]);
          tx_sh_r     <= tx_data_in << dw;
          tx_left_r   <= `SFC_BYTE_BITS - {1'b0, dw};
        end else begin
          io_out    <= out_bits(tx_sh_r, attr_r[`SFC_A_DLN]);
          tx_sh_r   <= tx_sh_r << dw;
          tx_left_r <= tx_left_r - {1'b0, dw};
        end
      end
    end
  end

  // Standby and idle never enable the output driver

  // ****************************************************************
  // Received data buffer
  // ****************************************************************
  sfc_buf2 #(
    .W (8)
  ) u_rx_buf (
    .clk_in        (clk_in),
    .rstn_in       (rstn_in),
    .in_data_in    (push_data_r),
    .in_valid_in   (push_r),
    .in_ready_out  (buf_ready),
    .out_data_out  (rx_data_out),
    .out_valid_out (rx_valid_out),
    .out_ready_in  (rx_ready_in)
  );

endmodule // sfc_front_end

`default_nettype wire

/* tb/sfc_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************
// Front end checker
// ****************
module sfc_props (
  input wire logic       clk_in,
  input wire logic       rstn_in,
  input wire logic       cs_n_in,
  input wire logic [3:0] io_oe_out,
  input wire logic       cmd_exec_out,
  input wire logic       cmd_reject_out,
  input wire logic [7:0] cmd_op_out,
  input wire logic [8:0] sector_out,
  input wire logic [5:0] block32_out,
  input wire logic [4:0] block64_out,
  input wire logic       active_out,
  input wire logic       standby_out,
  input wire logic       quad_command_mode_out,
  input wire logic       fast_quad_read_mode_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // Chip select seen high for a while
  sequence cs_idle;
    cs_n_in [*8];
  endsequence
  // Reset held over two edges
  sequence rst_held;
    !rstn_in ##1 !rstn_in;
  endsequence
  a_standby_hiz: assert property (standby_out |-> io_oe_out == 4'h0)
    else $error("pins driven in standby");
  a_state_excl: assert property (!(active_out && standby_out))
    else $error("active and standby together");
  a_idle_release: assert property (cs_idle |-> io_oe_out == 4'h0 && !active_out)
    else $error("still active after deselect");
  a_exec_deselect: assert property (cmd_exec_out |-> cs_n_in && !cmd_reject_out)
    else $error("command run while selected");
  a_quad_entry: assert property ($rose(quad_command_mode_out) |-> cmd_op_out == 8'h35)
    else $error("quad mode without entry opcode");
  a_quad_exit: assert property ($fell(quad_command_mode_out) |-> cmd_op_out == 8'hf5)
    else $error("quad mode left without exit opcode");
  a_fast_read: assert property (fast_quad_read_mode_out |-> cmd_op_out == 8'heb)
    else $error("fast read without its opcode");
  a_block_map: assert property (block32_out == sector_out[8:3] && block64_out == sector_out[8:4])
    else $error("block numbers off sector");
  a_reset_idle: assert property (disable iff (1'b0) rst_held |-> !active_out && !standby_out
    && !quad_command_mode_out && io_oe_out == 4'h0) else $error("not idle in reset");
endmodule // sfc_props

bind sfc_front_end sfc_props u_props (.clk_in(clk_in), .rstn_in(rstn_in), .cs_n_in(cs_n_in),
  .io_oe_out(io_oe_out), .cmd_exec_out(cmd_exec_out), .cmd_reject_out(cmd_reject_out),
  .cmd_op_out(cmd_op_out), .sector_out(sector_out), .block32_out(block32_out),
  .block64_out(block64_out), .active_out(active_out), .standby_out(standby_out),
  .quad_command_mode_out(quad_command_mode_out),
  .fast_quad_read_mode_out(fast_quad_read_mode_out));
`default_nettype wire

/* tb/sfc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************
// Host controller model
// ****************
module sfc_host_model (
  output logic            cs_n_out,
  output logic            sclk_out,
  output logic [3:0]      io_out,
  input  wire logic [3:0] io_in
);
  localparam realtime HALF = 62.5;
  logic cpol_r;
  logic drv_r;
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    io_out = 4'h0;
    cpol_r = 1'b0;
    drv_r = 1'b1;
  end
  // Released lines change every half period, never a stale level
  always #(HALF) if (!drv_r) io_out = ~io_out;
  // Frame start with the clock parked at its idle level
  task open(input logic pol);
    cpol_r = pol;
    sclk_out = pol;
    #(HALF) cs_n_out = 1'b0;
    #(HALF);
  endtask
  // Data changes while clock low, sampled at the rise
  task shift(input logic [23:0] v, input int n, input int ln, input logic drv,
             output logic [7:0] r);
    r = 8'h00;
    drv_r = drv;
    for (int i = n; i > 0; i -= ln) begin
      sclk_out = 1'b0;
      if (drv) io_out = (ln == 4) ? v[i-1 -: 4] : {3'h0, v[i-1]};
      #(HALF) sclk_out = 1'b1;
      r = (ln == 4) ? {r[3:0], io_in} : {r[6:0], io_in[1]};
      #(HALF);
    end
  endtask
  // Deselect where the caller stopped, byte edge or not
  task close();
    sclk_out = cpol_r;
    #(HALF) cs_n_out = 1'b1;
    drv_r = 1'b1;
    #(HALF * 4);
  endtask
endmodule // sfc_host_model
`default_nettype wire

/* tb/serial_flash_command_front_end_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_flash_command_front_end_tb;
  logic clk_in = 0, rstn_in = 0, busy = 0, rdy = 0;
  logic [7:0] txd = 0, rd, b, rxd, op;
  logic [3:0] hio, dio, oe;
  logic [8:0] sec;
  logic [5:0] b32;
  logic [4:0] b64;
  logic [23:0] a;
  logic cs_n, sclk, rxv, ovr, ex, rj, act, stb, quad, fast, tk;
  logic [23:0] adr;
  wire [3:0] io_w = (oe & dio) | (~oe & hio);
  int n_mismatch = 0, total_checks = 0, n_ovr = 0, n_take = 0;
  logic [8:0] exp_q[$];
  logic [7:0] rx_q[$];
  initial forever #4 clk_in = ~clk_in;
  sfc_host_model h (.cs_n_out(cs_n), .sclk_out(sclk), .io_out(hio), .io_in(io_w));
  sfc_front_end u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .cs_n_in(cs_n), .sclk_in(sclk),
    .io_in(io_w), .io_out(dio), .io_oe_out(oe), .busy_in(busy), .tx_data_in(txd),
    .tx_take_out(tk), .rx_data_out(rxd), .rx_valid_out(rxv), .rx_ready_in(rdy),
    .rx_overrun_out(ovr), .cmd_op_out(op), .cmd_addr_out(adr), .sector_out(sec),
    .block32_out(b32), .block64_out(b64), .cmd_exec_out(ex), .cmd_reject_out(rj),
    .active_out(act), .standby_out(stb), .quad_command_mode_out(quad),
    .fast_quad_read_mode_out(fast));
  task chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // Opcode then optional stray bits, frame left open
  task cmd(input logic pol, input logic [7:0] o, input int ln, input int xb);
    h.open(pol);
    h.shift({16'h0, o}, 8, ln, 1'b1, rd);
    if (xb > 0) h.shift(24'h0, xb, 1, 1'b1, rd);
  endtask
  task fin();
    h.close();
    tick(12);
  endtask
  task tally_and_finish();
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Take the oldest note whenever an outcome shows
  always @(posedge clk_in) begin
    if (ex || rj) chk(exp_q.size() > 0 && exp_q.pop_front() === {ex, op}, "outcome");
    if (rxv && rdy) chk(rx_q.size() > 0 && rx_q.pop_front() === rxd, "rx byte");
    if (ovr) n_ovr++;
    if (tk) n_take++;
  end
  // Watchdog
  initial begin
    #500000;
    n_mismatch++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    void'($urandom(32'h56490c05));
    tick(16);
    rstn_in = 1;
    tick(4);
    chk(quad === 0 && act === 0 && stb === 0 && oe === 4'h0, "reset state");
    for (int p = 0; p < 2; p++) begin
      exp_q.push_back({1'b1, 8'h06});
      cmd(p[0], 8'h06, 1, 0);
      chk(act === 1'b1, "not active");
      fin();
      chk(act === 1'b0, "active after deselect");
    end
    exp_q.push_back({1'b0, 8'h06});
    cmd(1'b1, 8'h06, 1, 3);
    fin();
    for (int i = 0; i < 2; i++) begin
      cmd(1'b0, i ? 8'hf5 : 8'hff, 1, 0);
      h.shift(24'h0, 12, 1, 1'b1, rd);
      chk(stb === 1'b1 && oe === 4'h0 && act === 1'b0, "standby");
      fin();
    end
    txd = $urandom;
    cmd(1'b1, 8'h05, 1, 0);
    chk(stb === 1'b0, "standby kept");
    h.shift(24'h0, 8, 1, 1'b0, rd);
    chk(rd === txd && oe === 4'h2, "status out");
    h.shift(24'h0, 3, 1, 1'b0, rd);
    fin();
    chk(n_take == 2, "byte take count");
    busy = 1;
    exp_q.push_back({1'b0, 8'h20});
    cmd(1'b0, 8'h20, 1, 0);
    h.shift(24'h0, 24, 1, 1'b1, rd);
    fin();
    busy = 0;
    for (int i = 0; i < 3; i++) begin
      a = (i == 0) ? 24'h0ff000 : (i == 1) ? 24'h0fffff : 24'($urandom) & 24'h0fffff;
      exp_q.push_back({1'b1, 8'h20});
      cmd(1'b0, 8'h20, 1, 0);
      h.shift(a, 24, 1, 1'b1, rd);
      fin();
      chk(sec === a[20:12] && b32 === a[20:15] && b64 === a[20:16], "map");
    end
    exp_q.push_back({1'b1, 8'h02});
    cmd(1'b0, 8'h02, 1, 0);
    h.shift(24'h0, 24, 1, 1'b1, rd);
    for (int k = 0; k < 3; k++) begin
      b = $urandom;
      if (k < 2) rx_q.push_back(b);
      h.shift({16'h0, b}, 8, 1, 1'b1, rd);
    end
    fin();
    chk(n_ovr == 1, "overrun");
    rdy = 1;
    tick(8);
    chk(rx_q.size() == 0 && rxv === 1'b0, "drain");
    exp_q.push_back({1'b1, 8'h35});
    cmd(1'b0, 8'h35, 1, 0);
    fin();
    chk(quad === 1'b1, "quad entry");
    txd = $urandom;
    cmd(1'b0, 8'heb, 4, 0);
    h.shift(24'h012345, 24, 4, 1'b1, rd);
    chk(adr === 24'h012345, "quad address");
    h.shift(24'h0, 24, 4, 1'b0, rd);
    chk(fast === 1'b1, "fast read");
    h.shift(24'h0, 8, 4, 1'b0, rd);
    chk(rd === txd && oe === 4'hf, "quad data");
    fin();
    cmd(1'b0, 8'h03, 4, 0);
    fin();
    chk(stb === 1'b1, "quad unknown");
    exp_q.push_back({1'b1, 8'hf5});
    cmd(1'b0, 8'hf5, 4, 0);
    fin();
    chk(quad === 1'b0 && exp_q.size() == 0, "quad exit");
    tally_and_finish();
  end
endmodule // serial_flash_command_front_end_tb
`default_nettype wire
